// ### cavr_consts.vh
/*
  Constants for the CA reference mode register block: address, field
  positions and reset values.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CAVR_CONSTS_VH
`define CAVR_CONSTS_VH

`define CAVR_ADDR_W         6
`define CAVR_REG_ADDR       6'h0C
`define CAVR_DATA_W         8
`define CAVR_LEVEL_W        6
`define CAVR_LEVEL_LSB      0
`define CAVR_LEVEL_MSB      5
`define CAVR_RANGE_BIT      6
`define CAVR_RSVD_BIT       7
`define CAVR_LEVEL_RESET    6'h0D
`define CAVR_RANGE_RESET    1'h1
`define CAVR_LEVEL_MAX      6'h32
`define CAVR_DQ_W           16

`endif

// ### cavr_setpoint_copy.v
/*
  One set point copy of the CA reference register: level code and range.
  Assumes the caller gates the write strobe with the set point selection.
*/
`include "cavr_consts.vh"

module cavr_setpoint_copy (
  // Clock and reset
  input  wire                        mclk,
  input  wire                        sys_rst,
  // Write port
  input  wire                        wr_en,
  input  wire [`CAVR_DATA_W-1:0]     wr_data,
  // Stored content
  output reg  [`CAVR_LEVEL_W-1:0]    level,
  output reg                         range_sel
);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      level     <= `CAVR_LEVEL_RESET;
      range_sel <= `CAVR_RANGE_RESET;
    end else if (wr_en) begin
      // Level and range land together in one write
      level     <= wr_data[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB];
      range_sel <= wr_data[`CAVR_RANGE_BIT];
    end
  end

endmodule // cavr_setpoint_copy

// ### cavr_ca_vref_control.v
/*
  CA reference mode register (ca_vref_control), held in two set point
  copies, reached by mode register write and read commands.
  Assumes the command decoder delivers one-cycle strobes with address and
  operand, and supplies the set point select bits from the set point
  control register, all synchronous to mclk.
  A read answers one cycle after its strobe; a write reaches the applied
  outputs two cycles after its strobe when the operate-select copy is hit.
  A write and a read in the same cycle return the value held before it.
  Bit seven of a write is dropped; it always reads back as zero.
*/
// Notes on behaviour
// - Two copies; access uses write-select copy
// - Operate from copy chosen by operate-select
// - Inactive copy writes leave operation unchanged
// - Read drives register bits onto DQ[7:0]
// - Reserved bit and unused lines read zero
// - Level write targets copy by write-select
// - Bit six picks range; range one default
// - Writing bit six switches the range
// - Values held until overwrite or reset
`include "cavr_consts.vh"

module cavr_ca_vref_control #(
  parameter DQ_W = `CAVR_DQ_W
) (
  // Clock and reset
  input  wire                        mclk,
  input  wire                        sys_rst,
  // Mode register commands
  input  wire                        mode_register_write_cmd,
  input  wire                        mode_register_read_cmd,
  input  wire [`CAVR_ADDR_W-1:0]     mode_register_address_field,
  input  wire [`CAVR_DATA_W-1:0]     operand_bits,
  // Set point selection from the set point control register
  input  wire                        setpoint_write_select,
  input  wire                        setpoint_operate_select,
  // Read data
  output reg  [DQ_W-1:0]             rd_dq,
  output reg                         rd_valid,
  // Applied reference setting
  output reg  [`CAVR_LEVEL_W-1:0]    ca_reference_level,
  output reg                         ca_reference_range_select,
  // Level code outside the defined set seen on a write
  output reg                         level_code_reserved
);

  // Width of the read lines above the register image
  localparam PAD_W = DQ_W - `CAVR_DATA_W;

  // Decoded command strobes
  wire                       hit;
  wire                       rd_hit;
  wire                       wr_hit;
  wire                       wr0;
  wire                       wr1;
  // Stored content of both set point copies
  wire [`CAVR_LEVEL_W-1:0]   level0;
  wire [`CAVR_LEVEL_W-1:0]   level1;
  wire                       range0;
  wire                       range1;
  // Copy seen by the command bus and copy that drives the receiver
  reg  [`CAVR_DATA_W-1:0]    sel_image;
  reg  [`CAVR_LEVEL_W-1:0]   op_level;
  reg                        op_range;
  // Next values of the registered outputs
  reg  [DQ_W-1:0]            next_rd_dq;
  reg                        next_rd_valid;
  reg  [`CAVR_LEVEL_W-1:0]   next_ca_reference_level;
  reg                        next_ca_reference_range_select;
  reg                        next_level_code_reserved;

  // True when a command carries this register's address
  function addr_hit;
    input [`CAVR_ADDR_W-1:0] addr;
    begin
      addr_hit = (addr == `CAVR_REG_ADDR);
    end
  endfunction

  // Builds the read image; the reserved bit is always zero
  function [`CAVR_DATA_W-1:0] image;
    input                     rng;
    input [`CAVR_LEVEL_W-1:0] lvl;
    begin
      image = {1'b0, rng, lvl};
    end
  endfunction

  // Level of set point one when sel is high, else of set point zero
  function [`CAVR_LEVEL_W-1:0] pick_level;
    input                     sel;
    input [`CAVR_LEVEL_W-1:0] lvl0;
    input [`CAVR_LEVEL_W-1:0] lvl1;
    begin
      if (sel) begin
        pick_level = lvl1;
      end else begin
        pick_level = lvl0;
      end
    end
  endfunction

  // Range of set point one when sel is high, else of set point zero
  function pick_range;
    input sel;
    input rng0;
    input rng1;
    begin
      if (sel) begin
        pick_range = rng1;
      end else begin
        pick_range = rng0;
      end
    end
  endfunction

  // Codes above the top defined level are reserved
  function code_reserved;
    input [`CAVR_LEVEL_W-1:0] lvl;
    begin
      code_reserved = (lvl > `CAVR_LEVEL_MAX);
    end
  endfunction

  assign hit    = addr_hit(mode_register_address_field);
  assign rd_hit = mode_register_read_cmd & hit;
  assign wr_hit = mode_register_write_cmd & hit;
  // Other addresses fall through with no effect on either copy
  assign wr0    = wr_hit & ~setpoint_write_select;
  assign wr1    = wr_hit & setpoint_write_select;

  // One physical copy per set point; a write strobe reaches only one
  cavr_setpoint_copy u_copy0 (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .wr_en     (wr0),
    .wr_data   (operand_bits),
    .level     (level0),
    .range_sel (range0)
  );

  cavr_setpoint_copy u_copy1 (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .wr_en     (wr1),
    .wr_data   (operand_bits),
    .level     (level1),
    .range_sel (range1)
  );

  // Reads follow the write-select copy, not the operating one, so either
  // copy can be checked over the bus without disturbing the receiver
  always @* begin
    sel_image = image(pick_range(setpoint_write_select, range0, range1),
                      pick_level(setpoint_write_select, level0, level1));
    op_level  = pick_level(setpoint_operate_select, level0, level1);
    op_range  = pick_range(setpoint_operate_select, range0, range1);
  end

  always @* begin
    // Answer only this register's address; others stay silent
    next_rd_valid = rd_hit;
    if (rd_hit) begin
      // Upper lines zero-filled
      next_rd_dq = {{PAD_W{1'b0}}, sel_image};
    end else begin
      // Lines stay low between reads, so no stale image lingers
      next_rd_dq = {DQ_W{1'b0}};
    end
    // Only the operate-select copy reaches the receiver
    next_ca_reference_level        = op_level;
    next_ca_reference_range_select = op_range;
    // Flags a controller slip; the code is stored regardless
    next_level_code_reserved       = wr_hit &
      code_reserved(operand_bits[`CAVR_LEVEL_MSB:`CAVR_LEVEL_LSB]);
  end

  // Read answer: one cycle after the strobe, for one cycle
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= next_rd_valid;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_dq <= {DQ_W{1'b0}};
    end else begin
      rd_dq <= next_rd_dq;
    end
  end

  // Applied setting lags the stored copy by one cycle; the extra stage
  // keeps the receiver input free of the select mux and write decode
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ca_reference_level <= `CAVR_LEVEL_RESET;
    end else begin
      ca_reference_level <= next_ca_reference_level;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ca_reference_range_select <= `CAVR_RANGE_RESET;
    end else begin
      ca_reference_range_select <= next_ca_reference_range_select;
    end
  end

  // Status pulse, one cycle per offending write
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      level_code_reserved <= 1'b0;
    end else begin
      level_code_reserved <= next_level_code_reserved;
    end
  end

endmodule // cavr_ca_vref_control

// ### cavr_props.sv
/* Port assertions on the CA reference register; assumes a bind into that module. */
module cavr_props #(parameter DQ_W = 16) (
  input wire mclk, sys_rst, mode_register_write_cmd, mode_register_read_cmd,
  input wire [5:0] mode_register_address_field, ca_reference_level,
  input wire [7:0] operand_bits,
  input wire setpoint_write_select, setpoint_operate_select, rd_valid,
  input wire [DQ_W-1:0] rd_dq,
  input wire ca_reference_range_select, level_code_reserved);
  timeunit 1ns; timeprecision 1ps;
  wire h = mode_register_address_field == 6'h0C;
  wire w = mode_register_write_cmd && h, r = mode_register_read_cmd && h;
  wire o = setpoint_operate_select, s = setpoint_write_select == setpoint_operate_select;
  wire f = w && operand_bits[5:0] > 6'h32;
  wire [6:0] ap = {ca_reference_range_select, ca_reference_level};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_VALID: assert property (rd_valid == $past(r)) else $error("valid");
  AST_TOP: assert property (rd_dq[DQ_W-1:7] == 0) else $error("top");
  AST_IDLE: assert property (!rd_valid |-> rd_dq == 0) else $error("idle");
  AST_RD: assert property (r && s && $stable(o) && !$past(w) |=> rd_dq[6:0] == $past(ap))
    else $error("read");
  AST_APPLY: assert property (w && s ##1 $stable(o) |=> ap == $past(operand_bits[6:0], 2))
    else $error("apply");
  AST_INACT: assert property (w && !s ##1 $stable(o) |=> $stable(ap)) else $error("inact");
  AST_HOLD: assert property (!w ##1 $stable(o) |=> $stable(ap)) else $error("hold");
  AST_FLAG: assert property (level_code_reserved == $past(f)) else $error("flag");
  cover property (w ##1 r);
  cover property (f);
  cover property ($rose(o));
endmodule // cavr_props
bind cavr_ca_vref_control cavr_props #(.DQ_W(DQ_W)) cavr_props_i (.*);

// ### cavr_mc.sv
/* Controller model issuing mode register commands; assumes calls 1 ns after an mclk rise. */
module cavr_mc (
  input  wire        mclk,
  output logic       w, r, ws, os,
  output logic [5:0] a,
  output logic [7:0] d);
  timeunit 1ns; timeprecision 1ps;
  initial {w, r, ws, os, a, d} = 0;
  // Range and level always travel in one write; codes above 110010B only for the flag test
  task cmd(logic iw, ir, logic [5:0] ia, logic [7:0] id, logic iws, ios);
    {w, r, a, d, ws, os} = {iw, ir, ia, id, iws, ios};
    @(posedge mclk) #1;
  endtask
  // Released lines show the inverse of their last value, so a stale copy cannot pass
  task idle; {w, r, a, d} = {2'b0, ~a, ~d}; @(posedge mclk) #1; endtask
endmodule // cavr_mc

// ### cavr_ca_vref_control_tb_top.sv
/* Command sequences with expected register contents; assumes cavr_mc and the checker. */
module cavr_ca_vref_control_tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic mclk = 0, sys_rst = 1;
  wire w, r, ws, os, v, rg, fl;
  wire [5:0] a, lv;
  wire [7:0] d;
  wire [15:0] dq;
  int bad_count = 0, tests_run = 0;
  initial forever #20 mclk = ~mclk;
  cavr_mc cavr_mc_i (.mclk(mclk), .w(w), .r(r), .ws(ws), .os(os), .a(a), .d(d));
  cavr_ca_vref_control cavr_ca_vref_control_i (.mclk(mclk), .sys_rst(sys_rst), .rd_dq(dq),
    .mode_register_write_cmd(w), .mode_register_read_cmd(r), .mode_register_address_field(a),
    .operand_bits(d), .setpoint_write_select(ws), .setpoint_operate_select(os), .rd_valid(v),
    .ca_reference_level(lv), .ca_reference_range_select(rg), .level_code_reserved(fl));
  task chk(string n, logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin bad_count++; $display("[ERR] %s exp %h seen %h", n, e, s); end
  endtask
  task rd(logic [7:0] e, logic iws, ios, logic [5:0] ia = 6'h0C);
    cavr_mc_i.cmd(0, 1, ia, 0, iws, ios);
    chk("valid", v, ia == 6'h0C);
    chk("dq", dq, e);
    cavr_mc_i.idle;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    chk("rst", {rg, lv}, 7'h4D);
    rd(8'h4D, 1, 0);
    cavr_mc_i.cmd(1, 0, 6'h0C, 8'h32, 0, 0);
    chk("flag0", fl, 0);
    rd(8'h32, 0, 0);
    chk("sp0", {rg, lv}, 7'h32);
    cavr_mc_i.cmd(1, 0, 6'h0C, 8'h45, 1, 0);
    rd(8'h45, 1, 0);
    chk("inact", {rg, lv}, 7'h32);
    cavr_mc_i.cmd(1, 0, 6'h0C, 8'hBF, 1, 1);
    chk("flag", fl, 1);
    rd(8'h3F, 1, 1);
    cavr_mc_i.cmd(1, 0, 6'h0B, 8'h21, 1, 1);
    rd(0, 1, 1, 6'h0B);
    rd(8'h3F, 1, 1);
    rd(8'h32, 0, 1);
    chk("sp1", {rg, lv}, 7'h3F);
    sys_rst = 1;
    #80 sys_rst = 0;
    chk("rst2", {rg, lv}, 7'h4D);
    rd(8'h4D, 0, 1);
    end_sim;
  end
endmodule // cavr_ca_vref_control_tb_top
